// ### bench/hplr_readout_properties.sv
// port-level assertions of the hit pipeline readout block
`timescale 1ns/100ps
`default_nettype none
module hplr_readout_checker (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // commands and sync
  input wire logic fastResetCmd,
  input wire logic stubSyncMark,
  // hit and link outputs
  input wire logic [hplr_pkg::NCH-1:0] stubHits,
  input wire logic anyChannelHitFlag,
  input wire logic serialOut,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic [hplr_pkg::AW-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  logic [8:0] bitPos_r;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  // index of the bit now on the link, 0 between frame slots
  always_ff @(posedge clk_sys) begin
    if (reset || fastResetCmd) begin
      bitPos_r <= 9'h0;
    end else if (bitPos_r != 9'h0) begin
      bitPos_r <= (bitPos_r == 9'h12f) ? 9'h0 : bitPos_r + 9'h1;
    end else if (serialOut) begin
      bitPos_r <= 9'h1;
    end
  end
  ready_after_access_a: assert property (psel && penable && !pready |=> pready)
    else $error("apb access not answered in one cycle");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  bad_addr_a: assert property (pready && paddr != hplr_pkg::CFG_OFS && paddr != hplr_pkg::STAT_OFS
      |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  hit_width_a: assert property ($changed(stubHits) |=> $stable(stubHits) [*7])
    else $error("stub hits changed within one crossing");
  flag_width_a: assert property ($changed(anyChannelHitFlag) |=> $stable(anyChannelHitFlag) [*7])
    else $error("any hit flag changed within one crossing");
  trunc_a: assert property (fastResetCmd |=> !serialOut)
    else $error("frame not cut by fast reset");
  idle_low_a: assert property (bitPos_r == 9'h0 && serialOut |-> $past(stubSyncMark, 2))
    else $error("link active outside a frame slot");
  header_a: assert property (bitPos_r == 9'h1 |-> serialOut)
    else $error("second header bit low");
  gap_zero_a: assert property (bitPos_r > 9'h113 |-> !serialOut)
    else $error("trailing gap not zero");
endmodule
bind hplr_readout hplr_readout_checker u_chk (
  .clk_sys(clk_sys), .reset(reset), .fastResetCmd(fastResetCmd), .stubSyncMark(stubSyncMark),
  .stubHits(stubHits), .anyChannelHitFlag(anyChannelHitFlag), .serialOut(serialOut), .psel(psel),
  .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr)
);
`default_nettype wire

// ### bench/hplr_rx_model.sv
// off-chip receiver model capturing triggered frames from the serial link
`timescale 1ns/100ps
`default_nettype none
module hplr_rx_model (
  // clock and shared command stream
  input wire logic clk_sys,
  input wire logic fastResetCmd,
  // link in
  input wire logic serialOut,
  // captured frame, first bit at the top
  output var logic [hplr_pkg::FRAME_BITS-1:0] frame,
  output var int frameCnt,
  output var logic gapErr
);
  int pos = 0;
  initial begin
    frame = '0;
    frameCnt = 0;
    gapErr = 1'b0;
  end
  // a frame starts on the first one seen while idle
  always @(posedge clk_sys) begin
    if (fastResetCmd) begin
      pos <= 0;
    end else if (pos > 0 || serialOut) begin
      if (pos < hplr_pkg::FRAME_BITS) begin
        frame <= {frame[hplr_pkg::FRAME_BITS-2:0], serialOut};
      end else if (serialOut) begin
        gapErr <= 1'b1;
      end
      if (pos == hplr_pkg::FRAME_BITS - 1) begin
        frameCnt <= frameCnt + 1;
      end
      pos <= (pos == hplr_pkg::SLOT_BITS - 1) ? 0 : pos + 1;
    end
  end
endmodule
`default_nettype wire

// ### bench/tb_top.sv
// self-checking bench of the hit pipeline readout block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk_sys = 1'b0;
  logic stubSyncMark = 1'b0;
  logic reset, fastResetCmd, triggerCmd, orbitResetCmd, psel, penable, pwrite, e;
  logic anyChannelHitFlag, serialOut, pready, pslverr, gapErr;
  logic [hplr_pkg::NCH-1:0] compIn, stubHits;
  logic [hplr_pkg::AW-1:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [hplr_pkg::FRAME_BITS-1:0] frame;
  int frameCnt;
  int n_fail = 0;
  int cmp_count = 0;
  int cyc = 0;
  // channels 1, 2 and 254 hit
  localparam logic [hplr_pkg::NCH-1:0] PAT = {1'b1, 251'h0, 2'h3};
  hplr_readout #(.BX_DIV(8), .REF_PHASE(4)) dut (
    .clk_sys(clk_sys), .reset(reset), .compIn(compIn), .fastResetCmd(fastResetCmd), .triggerCmd(triggerCmd),
    .orbitResetCmd(orbitResetCmd), .stubSyncMark(stubSyncMark), .stubHits(stubHits),
    .anyChannelHitFlag(anyChannelHitFlag), .serialOut(serialOut), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
  );
  hplr_rx_model rx (
    .clk_sys(clk_sys), .fastResetCmd(fastResetCmd), .serialOut(serialOut), .frame(frame),
    .frameCnt(frameCnt), .gapErr(gapErr)
  );
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  // sync slots wider than a frame slot, and the run ceiling
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    stubSyncMark <= (cyc % 320 == 0);
    if (cyc == 20000) begin
      n_fail++;
      summarize();
    end
  end
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [hplr_pkg::AW-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    chk("pready", 32'h1, 32'(pready));
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic cmd(input logic [2:0] m);
    {fastResetCmd, triggerCmd, orbitResetCmd} <= m;
    @(posedge clk_sys);
    {fastResetCmd, triggerCmd, orbitResetCmd} <= 3'h0;
    @(posedge clk_sys);
  endtask
  task automatic waitFrame(input int n);
    repeat (2000) if (frameCnt < n) @(posedge clk_sys);
    chk("frame count", 32'(n), 32'(frameCnt));
  endtask
  // 24-cycle comparator pulse on all channels, count high cycles of channel 1
  task automatic hitRun(input logic [31:0] cfg, input int exp);
    int hi;
    hi = 0;
    apb(1'b1, hplr_pkg::CFG_OFS, cfg);
    // keeps the fixed-mode rise off the blind BX-edge cycle
    @(posedge clk_sys);
    for (int i = 0; i < 88; i++) begin
      compIn <= (i < 24) ? '1 : '0;
      @(posedge clk_sys);
      if (stubHits[0] === 1'b1) hi++;
    end
    chk("hit cycles", 32'(exp), 32'(hi));
  endtask
  initial begin
    reset <= 1'b1;
    compIn <= '0;
    {fastResetCmd, triggerCmd, orbitResetCmd} <= 3'h0;
    {psel, penable, pwrite} <= 3'h0;
    paddr <= '0;
    pwdata <= 32'h0;
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    apb(1'b0, hplr_pkg::CFG_OFS, 32'h0);
    chk("cfg reset", hplr_pkg::CFG_RESET, q);
    apb(1'b0, 12'h008, 32'h0);
    chk("unmapped err", 32'h1, 32'(e));
    hitRun(32'h0000_0201, 8);
    hitRun(32'h0000_0205, 24);
    hitRun(32'h0000_0209, 24);
    hitRun(32'h0000_020d, 8);
    hitRun(32'h0000_023d, 16);
    apb(1'b1, hplr_pkg::CFG_OFS, 32'h0005_0305);
    compIn <= PAT;
    cmd(3'h5);
    repeat (200) @(posedge clk_sys);
    apb(1'b0, hplr_pkg::STAT_OFS, 32'h0);
    chk("status run", 32'h100, q & 32'h101);
    chk("any hit", 32'h1, 32'(anyChannelHitFlag));
    chk("stub route", 32'h1, 32'(stubHits[0]));
    cmd(3'h2);
    cmd(3'h2);
    waitFrame(1);
    chk("header", 32'h3, 32'(frame[275:274]));
    chk("flags", 32'h0, 32'(frame[273:272]));
    chk("trig count", 32'h1, 32'(frame[262:254]));
    chk("chan head", 32'hc000_0000, frame[253:222]);
    chk("chan tail", 32'h1, 32'(frame[221:0] == 222'h1));
    chk("pipe addr", 32'h1, 32'(9'(frame[271:263] - q[24:16] + 9'h5) <= 9'h1));
    waitFrame(2);
    chk("second count", 32'h2, 32'(frame[262:254]));
    repeat (700) @(posedge clk_sys);
    chk("no empty frame", 32'h2, 32'(frameCnt));
    chk("gap zeros", 32'h0, 32'(gapErr));
    apb(1'b1, hplr_pkg::CFG_OFS, 32'h0006_0305);
    repeat (20) @(posedge clk_sys);
    apb(1'b0, hplr_pkg::STAT_OFS, 32'h0);
    chk("latency error", 32'h1, q & 32'h1);
    // start right after a sync slot so no frame drains the buffer meanwhile
    while (stubSyncMark !== 1'b1) @(posedge clk_sys);
    repeat (34) cmd(3'h2);
    apb(1'b0, hplr_pkg::STAT_OFS, 32'h0);
    chk("full count", 32'h82, q & 32'hfe);
    while (serialOut !== 1'b1) @(posedge clk_sys);
    repeat (20) @(posedge clk_sys);
    cmd(3'h4);
    apb(1'b0, hplr_pkg::STAT_OFS, 32'h0);
    chk("reset empties", 32'h0, q & 32'hfe);
    chk("pointer restart", 32'h1, 32'(q[24:16] < 9'h4));
    repeat (400) @(posedge clk_sys);
    chk("truncated", 32'h2, 32'(frameCnt));
    summarize();
  end
endmodule
`default_nettype wire

// ### common/hplr_pkg.sv
// constants, field layouts and helpers of the hit pipeline and triggered readout block
package hplr_pkg;
  localparam int NCH = 254;
  localparam int PTR_W = 9;
  localparam int PIPE_DEPTH = 512;
  localparam int BUF_DEPTH = 32;
  localparam int BPTR_W = 5;
  localparam int BCNT_W = 6;
  localparam int HAM_W = 13;
  localparam int ENTRY_W = NCH + HAM_W;
  localparam int HIP_W = 3;
  localparam int DIV_W = 4;
  localparam int FRAME_BITS = 276;
  localparam int GAP_BITS = 28;
  // frame slot, in serial bit periods, from the 950 ns repeat time
  localparam int BX_NS = 25;
  localparam int BITS_PER_BX = 8;
  localparam int FRAME_PERIOD_NS = 950;
  localparam int SLOT_BITS = FRAME_PERIOD_NS * BITS_PER_BX / BX_NS;
  localparam int SLOT_W = 9;
  localparam logic [SLOT_W-1:0] SLOT_LAST = SLOT_W'(SLOT_BITS - 1);
  localparam logic [1:0] FRAME_HDR = 2'h3;
  localparam logic [BCNT_W-1:0] BUF_FULL = BCNT_W'(BUF_DEPTH);
  // hit variant codes used by both route selects
  localparam logic [1:0] SEL_FIXED = 2'h0;
  localparam logic [1:0] SEL_SAMPLED = 2'h1;
  localparam logic [1:0] SEL_OR = 2'h2;
  localparam logic [1:0] SEL_HIP = 2'h3;
  // APB map
  localparam int AW = 12;
  localparam logic [AW-1:0] CFG_OFS = 12'h000;
  localparam logic [AW-1:0] STAT_OFS = 12'h004;
  localparam int CF_PIPE = 0;
  localparam int CF_STUB = 2;
  localparam int CF_HIPSRC = 4;
  localparam int CF_HIPLIM = 5;
  localparam int CF_OREN = 8;
  localparam int CF_HSDLL = 9;
  localparam int CF_HSREF = 10;
  localparam int CF_LAT = 16;
  localparam int ST_LATERR = 0;
  localparam int ST_FULL = 1;
  localparam int ST_CNT = 2;
  localparam int ST_RUN = 8;
  localparam int ST_WR = 16;
  localparam logic [31:0] CFG_RESET = 32'h0000_0201;

  typedef enum logic [1:0] {TX_IDLE, TX_ARMED, TX_SEND} hplr_tx_t;

  // single-error-correcting code of a 9-bit pipeline address
  function automatic logic [HAM_W-1:0] hplrHamEnc(input logic [PTR_W-1:0] d);
    logic [HAM_W-1:0] c;
    int j;
    c = '0;
    j = 0;
    for (int p = 1; p <= HAM_W; p++) begin
      if ((p & (p - 1)) != 0) begin
        c[p-1] = d[j];
        j++;
      end
    end
    for (int k = 0; k < 4; k++) begin
      for (int p = 1; p <= HAM_W; p++) begin
        if (((p >> k) & 1) == 1 && p != (1 << k)) begin
          c[(1<<k)-1] = c[(1<<k)-1] ^ c[p-1];
        end
      end
    end
    return c;
  endfunction

  function automatic logic [PTR_W-1:0] hplrHamDec(input logic [HAM_W-1:0] cin);
    logic [HAM_W-1:0] c;
    logic [3:0] syn;
    logic [PTR_W-1:0] d;
    int j;
    c = cin;
    syn = '0;
    d = '0;
    j = 0;
    for (int p = 1; p <= HAM_W; p++) begin
      if (c[p-1]) begin
        syn = syn ^ 4'(p);
      end
    end
    if (syn != 4'h0 && int'(syn) <= HAM_W) begin
      c[syn-4'h1] = ~c[syn-4'h1];
    end
    for (int p = 1; p <= HAM_W; p++) begin
      if ((p & (p - 1)) != 0) begin
        d[j] = c[p-1];
        j++;
      end
    end
    return d;
  endfunction
endpackage

// ### logic/hplr_readout.sv
// hit detect, latency pipeline, event buffer and triggered frame serialiser
`timescale 1ns/100ps
`default_nettype none

// Operation
// - fixed-width mode catches a comparator rise outside the BX-edge cycle and outputs exactly one BX pulse.
// - fixed-width back-to-back hits need the comparator to fall between them.
// - sampled mode registers comparator each BX edge, clears on first edge after fall.
// - combined output is fixed-width OR sampled.
// - HIP stage on sampled or combined forces low once high for more than the 3-bit limit of BXs; at limit 7 the BX count saturates at 7 and never cuts.
// - independent selects route any variant to stub path and to pipeline.
// - fixed-width capture clears at next BX edge; activity in that blind slot lost.
// - OR of all 254 pipeline hits, reported as flag when enabled.
// - pipeline holds 512 BXs of 254 channels, one write and one read port.
// - fast reset initialises pipeline control so chips start in step.
// - 9-bit write counter starts at 0, advances each BX, wraps after 511.
// - trigger counter starts once programmed 9-bit latency has elapsed.
// - write minus trigger counter compared with latency; mismatch sets latency error.
// - trigger copies pipeline row at trigger pointer plus its address into buffer.
// - empty buffer blocks load and shift; present event is loaded and shifted.
// - up/down count of events; full flag at 32; both flags follow header.
// - buffer is 32 FIFO entries of 254 hits plus 13-bit Hamming address.
// - frame is 276 bits: header, errors, address, trigger count, 254 channels.
// - address and count MSB first, channels in order 1 to 254.
// - event loaded on BX timing and shifted at bit rate with handshake.
// - two config bits pick shifted or reference BX phase for load handshake.
// - header aligns to stub sync mark; 950 ns slots, 28 trailing zero bits.
// - fast reset truncates frame in flight and resets pipeline pointers.
// - 9-bit triple-redundant trigger counter, cleared by orbit reset, feeds frame.
module hplr_readout #(
  parameter int BX_DIV = 8,
  parameter int REF_PHASE = 4
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // comparator outputs, asynchronous
  input wire logic [hplr_pkg::NCH-1:0] compIn,
  // fast commands, one-cycle pulses from the command decoder
  input wire logic fastResetCmd,
  input wire logic triggerCmd,
  input wire logic orbitResetCmd,
  // stub stream sync mark, one-cycle pulse
  input wire logic stubSyncMark,
  // outputs towards stub logic and link
  output logic [hplr_pkg::NCH-1:0] stubHits,
  output logic anyChannelHitFlag,
  output logic serialOut,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [hplr_pkg::AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  localparam int N = hplr_pkg::NCH;
  localparam int PW = hplr_pkg::PTR_W;

  typedef struct packed {
    logic [N-1:0] sync1;
    logic [N-1:0] sync2;
    logic [N-1:0] prevComp;
    logic [N-1:0] fixLatch;
    logic [N-1:0] fixOut;
    logic [N-1:0] smpOut;
    logic [N-1:0][hplr_pkg::HIP_W-1:0] hipCnt;
    logic [N-1:0] stubOut;
    logic anyHit;
    logic [hplr_pkg::DIV_W-1:0] bxCnt;
    logic [PW-1:0] wrPtr;
    logic [PW-1:0] trigPtr;
    logic trigRun;
    logic latErr;
    logic [2:0][PW-1:0] l1Cnt;
    logic capPend;
    logic [PW-1:0] capAddr;
    logic [PW-1:0] capCnt;
    logic [hplr_pkg::BPTR_W-1:0] bufWr;
    logic [hplr_pkg::BPTR_W-1:0] bufRd;
    logic [hplr_pkg::BCNT_W-1:0] bufCnt;
    hplr_pkg::hplr_tx_t txState;
    logic [hplr_pkg::SLOT_W-1:0] bitCnt;
    logic [hplr_pkg::FRAME_BITS-1:0] shifter;
    logic serOut;
    logic [31:0] cfg;
    logic [31:0] rdData;
    logic ready;
    logic slvErr;
  } hplr_state_t;

  hplr_state_t r;
  hplr_state_t n;

  // storage kept out of the state struct: plain arrays map onto RAM
  logic [N-1:0] pipeMem [hplr_pkg::PIPE_DEPTH];
  logic [hplr_pkg::ENTRY_W-1:0] bufMem [hplr_pkg::BUF_DEPTH];
  logic [PW-1:0] l1Mem [hplr_pkg::BUF_DEPTH];
  logic [N-1:0] pipeRow;

  logic bxEn;
  logic refEn;
  logic hsEn;
  logic [N-1:0] fixHit;
  logic [N-1:0] orHit;
  logic [N-1:0] hipSrcHit;
  logic [N-1:0] hipHit;
  logic [N-1:0][hplr_pkg::HIP_W-1:0] hipCntNxt;
  logic [N-1:0] pipeHit;
  logic [N-1:0] stubHit;
  logic [1:0] pipeSel;
  logic [1:0] stubSel;
  logic [hplr_pkg::HIP_W-1:0] hipLimit;
  logic [PW-1:0] latency;
  logic [PW-1:0] l1Vote;
  logic [N-1:0] rise;
  logic bufWrite;
  logic apbAccess;

  assign pipeSel = r.cfg[hplr_pkg::CF_PIPE +: 2];
  assign stubSel = r.cfg[hplr_pkg::CF_STUB +: 2];
  assign hipLimit = r.cfg[hplr_pkg::CF_HIPLIM +: hplr_pkg::HIP_W];
  assign latency = r.cfg[hplr_pkg::CF_LAT +: PW];
  assign bxEn = (r.bxCnt == hplr_pkg::DIV_W'(BX_DIV - 1));
  assign refEn = (r.bxCnt == hplr_pkg::DIV_W'(REF_PHASE));
  // reference phase only when it alone is chosen
  assign hsEn = (r.cfg[hplr_pkg::CF_HSREF] && !r.cfg[hplr_pkg::CF_HSDLL]) ? refEn : bxEn;
  assign rise = r.sync2 & ~r.prevComp;
  assign fixHit = r.fixOut;
  assign orHit = r.fixOut | r.smpOut;
  assign hipSrcHit = r.cfg[hplr_pkg::CF_HIPSRC] ? orHit : r.smpOut;
  assign l1Vote = (r.l1Cnt[0] & r.l1Cnt[1]) | (r.l1Cnt[0] & r.l1Cnt[2]) | (r.l1Cnt[1] & r.l1Cnt[2]);
  assign bufWrite = r.capPend;
  assign apbAccess = psel && penable && !r.ready;

  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : gChan
      // count BXs the source has already been high; cut once past the limit
      assign hipHit[gi] = hipSrcHit[gi] && (r.hipCnt[gi] <= hipLimit);
      assign hipCntNxt[gi] = !hipSrcHit[gi] ? '0 :
        ((r.hipCnt[gi] == '1) ? r.hipCnt[gi] : r.hipCnt[gi] + 1'b1);
      assign pipeHit[gi] = (pipeSel == hplr_pkg::SEL_FIXED) ? fixHit[gi] :
        (pipeSel == hplr_pkg::SEL_SAMPLED) ? r.smpOut[gi] :
        (pipeSel == hplr_pkg::SEL_OR) ? orHit[gi] : hipHit[gi];
      assign stubHit[gi] = (stubSel == hplr_pkg::SEL_FIXED) ? fixHit[gi] :
        (stubSel == hplr_pkg::SEL_SAMPLED) ? r.smpOut[gi] :
        (stubSel == hplr_pkg::SEL_OR) ? orHit[gi] : hipHit[gi];
    end
  endgenerate

  always_comb begin
    logic [PW-1:0] wrNew;
    logic [PW-1:0] trigNew;
    logic [PW-1:0] cntNew;
    logic doLoad;
    logic [N-1:0] chanRev;
    logic [hplr_pkg::ENTRY_W-1:0] entry;
    wrNew = '0;
    trigNew = '0;
    cntNew = '0;
    doLoad = 1'b0;
    chanRev = '0;
    entry = bufMem[r.bufRd];
    n = r;
    n.sync1 = compIn;
    n.sync2 = r.sync1;
    n.prevComp = r.sync2;
    n.bxCnt = bxEn ? '0 : r.bxCnt + 1'b1;
    // capture between BX edges; a rise in the clearing cycle is dropped
    if (bxEn) begin
      n.fixOut = r.fixLatch;
      n.fixLatch = '0;
      n.smpOut = r.sync2;
      n.hipCnt = hipCntNxt;
      n.stubOut = stubHit;
      n.anyHit = r.cfg[hplr_pkg::CF_OREN] && (|pipeHit);
    end else begin
      n.fixLatch = r.fixLatch | rise;
    end

    // pipeline pointers
    if (bxEn) begin
      wrNew = r.wrPtr + 1'b1;
      trigNew = r.trigRun ? r.trigPtr + 1'b1 : r.trigPtr;
      n.wrPtr = wrNew;
      n.trigPtr = trigNew;
      if (!r.trigRun && wrNew == latency) begin
        n.trigRun = 1'b1;
        n.trigPtr = '0;
        trigNew = '0;
      end
      n.latErr = (r.trigRun || n.trigRun) && (PW'(wrNew - trigNew) != latency);
    end

    // trigger counter with voting across three copies
    cntNew = orbitResetCmd ? '0 : (triggerCmd ? l1Vote + 1'b1 : l1Vote);
    for (int k = 0; k < 3; k++) begin
      n.l1Cnt[k] = cntNew;
    end

    // trigger capture; the pipeline row arrives one cycle later
    n.capPend = 1'b0;
    if (triggerCmd && r.bufCnt != hplr_pkg::BUF_FULL) begin
      n.capPend = 1'b1;
      n.capAddr = r.trigPtr;
      n.capCnt = cntNew;
    end

    // frame transmitter
    n.serOut = 1'b0;
    case (r.txState)
      hplr_pkg::TX_IDLE: begin
        if (r.bufCnt != '0 && hsEn) begin
          n.txState = hplr_pkg::TX_ARMED;
        end
      end
      hplr_pkg::TX_ARMED: begin
        if (stubSyncMark) begin
          doLoad = 1'b1;
          chanRev = {<<{entry[N-1:0]}};
          n.shifter = {hplr_pkg::FRAME_HDR, r.latErr, (r.bufCnt == hplr_pkg::BUF_FULL),
            hplr_pkg::hplrHamDec(entry[N +: hplr_pkg::HAM_W]), l1Mem[r.bufRd], chanRev};
          n.bitCnt = '0;
          n.txState = hplr_pkg::TX_SEND;
          n.bufRd = r.bufRd + 1'b1;
        end
      end
      hplr_pkg::TX_SEND: begin
        // msb leaves first; zeros shift in and fill the gap bits
        n.serOut = r.shifter[hplr_pkg::FRAME_BITS-1];
        n.shifter = {r.shifter[hplr_pkg::FRAME_BITS-2:0], 1'b0};
        n.bitCnt = r.bitCnt + 1'b1;
        if (r.bitCnt == hplr_pkg::SLOT_LAST) begin
          n.txState = hplr_pkg::TX_IDLE;
        end
      end
      default: begin
        n.txState = hplr_pkg::TX_IDLE;
      end
    endcase

    // event bookkeeping, both directions may happen in one cycle
    if (bufWrite) begin
      n.bufWr = r.bufWr + 1'b1;
    end
    n.bufCnt = r.bufCnt + (bufWrite ? 1'b1 : 1'b0) - (doLoad ? 1'b1 : 1'b0);

    // APB, one wait state on every access
    n.ready = 1'b0;
    n.slvErr = 1'b0;
    // write lands only at the completion edge, where pready is seen high
    if (psel && penable && r.ready && pwrite && paddr == hplr_pkg::CFG_OFS) begin
      n.cfg = pwdata;
    end
    if (apbAccess) begin
      n.ready = 1'b1;
      n.rdData = '0;
      case (paddr)
        hplr_pkg::CFG_OFS: begin
          n.rdData = r.cfg;
        end
        hplr_pkg::STAT_OFS: begin
          n.rdData[hplr_pkg::ST_LATERR] = r.latErr;
          n.rdData[hplr_pkg::ST_FULL] = (r.bufCnt == hplr_pkg::BUF_FULL);
          n.rdData[hplr_pkg::ST_CNT +: hplr_pkg::BCNT_W] = r.bufCnt;
          n.rdData[hplr_pkg::ST_RUN] = r.trigRun;
          n.rdData[hplr_pkg::ST_WR +: PW] = r.wrPtr;
        end
        default: begin
          n.slvErr = 1'b1;
        end
      endcase
    end

    // fast reset: restart pointers in step, drop frame and queued events
    if (fastResetCmd) begin
      n.wrPtr = '0;
      n.trigPtr = '0;
      n.trigRun = (latency == '0);
      n.latErr = 1'b0;
      n.capPend = 1'b0;
      n.bufWr = '0;
      n.bufRd = '0;
      n.bufCnt = '0;
      n.txState = hplr_pkg::TX_IDLE;
      n.shifter = '0;
      n.serOut = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      r <= '0;
      r.cfg <= hplr_pkg::CFG_RESET;
      r.txState <= hplr_pkg::TX_IDLE;
    end else begin
      r <= n;
    end
  end

  // one write port and one read port on the pipeline
  always_ff @(posedge clk_sys) begin
    if (bxEn) begin
      pipeMem[r.wrPtr] <= pipeHit;
    end
    if (triggerCmd) begin
      pipeRow <= pipeMem[r.trigPtr];
    end
    if (bufWrite) begin
      bufMem[r.bufWr] <= {hplr_pkg::hplrHamEnc(r.capAddr), pipeRow};
      l1Mem[r.bufWr] <= r.capCnt;
    end
  end

  assign stubHits = r.stubOut;
  assign anyChannelHitFlag = r.anyHit;
  assign serialOut = r.serOut;
  assign prdata = r.rdData;
  assign pready = r.ready;
  assign pslverr = r.slvErr;
endmodule
`default_nettype wire
